/* File: rtl/cvt_params.svh */
// Constants of the converter trim register bank: offsets, widths, reset values.
// Assumes byte addresses on a 12-bit register port with 16-bit data.
`ifndef CVT_PARAMS_SVH
`define CVT_PARAMS_SVH

`define CVT_ADDR_W 12
`define CVT_DATA_W 16
`define CVT_OFS_REG_W 16
`define CVT_GAIN_REG_W 8
`define CVT_OFS_FIELD_W 12
`define CVT_GAIN_FIELD_W 5
`define CVT_OFS_FIELD_LSB 0
`define CVT_GAIN_FIELD_LSB 0
`define CVT_TRIM_RESET 16'h0000
`define CVT_RD_IDLE 16'h0000

`define CVT_CORE2_SECOND_INPUT_OFFSET_TRIM 12'h336
`define CVT_CORE3_THIRD_INPUT_OFFSET_TRIM 12'h338
`define CVT_CORE3_FOURTH_INPUT_OFFSET_TRIM 12'h33A
`define CVT_CORE4_OFFSET_TRIM 12'h33C
`define CVT_CORE5_OFFSET_TRIM 12'h33E
`define CVT_CORE0_FINE_GAIN_TRIM 12'h360
`define CVT_CORE1_FINE_GAIN_TRIM 12'h361
`define CVT_CORE2_FIRST_INPUT_GAIN_TRIM 12'h362
`define CVT_CORE2_SECOND_INPUT_GAIN_TRIM 12'h363
`define CVT_CORE3_THIRD_INPUT_GAIN_TRIM 12'h364

`endif

/* File: rtl/cvt_pkg.sv */
// Types of the converter trim register bank.
// Assumes nothing of its surroundings.
`default_nettype none
package cvt_pkg;
	typedef enum logic [1:0] {
		CVT_WAIT_FUSE = 2'b00,
		CVT_LOAD      = 2'b01,
		CVT_RUN       = 2'b11
	} cvt_state_e;
	typedef logic [11:0] cvt_addr_t;
endpackage : cvt_pkg
`default_nettype wire

/* File: rtl/cvt_trim_bank.sv */
// Converter trim register bank: offset and fine gain trims per converter core.
// Assumes fuse values from a fuse reader on ref_clk, input selects from core control
// on ref_clk, and the neighbouring-bank core 2 first pair offset and core 3 fourth pair gain.
//
// Operation
// - Offset 0x336 holds core 2 offset while it digitises the second input pair.
// - Offset 0x338 holds core 3 offset while it digitises the third input pair.
// - Offset 0x33A holds core 3 offset while it digitises the fourth input pair.
// - Offset 0x33C holds core 4 offset, whatever the input selection.
// - Offset 0x33E holds core 5 offset, whatever the input selection.
// - Bits 4:0 at 0x360 hold core 0 fine gain.
// - Bits 4:0 at 0x361 hold core 1 fine gain.
// - Bits 4:0 at 0x362 hold core 2 gain on the first input pair.
// - Bits 4:0 at 0x363 hold core 2 gain on the second input pair.
// - Register 0x364 holds core 3 gain on the third input pair.
// - Every trim field is cleared to zero by reset, then loaded from its fuse value.
// - Offset trim fields are unsigned numbers.
`include "cvt_params.svh"
`default_nettype none
module cvt_trim_bank (
	input  wire logic                         ref_clk,
	input  wire logic                         arst_n,
	input  wire logic [`CVT_ADDR_W-1:0]       reg_addr,
	input  wire logic [`CVT_DATA_W-1:0]       reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [`CVT_DATA_W-1:0]       reg_rdata,
	input  wire logic                         fuse_valid,
	input  wire logic [`CVT_OFS_FIELD_W-1:0]  fuse_core2_second_offset,
	input  wire logic [`CVT_OFS_FIELD_W-1:0]  fuse_core3_third_offset,
	input  wire logic [`CVT_OFS_FIELD_W-1:0]  fuse_core3_fourth_offset,
	input  wire logic [`CVT_OFS_FIELD_W-1:0]  fuse_core4_offset,
	input  wire logic [`CVT_OFS_FIELD_W-1:0]  fuse_core5_offset,
	input  wire logic [`CVT_GAIN_FIELD_W-1:0] fuse_core0_gain,
	input  wire logic [`CVT_GAIN_FIELD_W-1:0] fuse_core1_gain,
	input  wire logic [`CVT_GAIN_FIELD_W-1:0] fuse_core2_first_gain,
	input  wire logic [`CVT_GAIN_FIELD_W-1:0] fuse_core2_second_gain,
	input  wire logic [`CVT_GAIN_FIELD_W-1:0] fuse_core3_third_gain,
	input  wire logic                         core2_second_pair,
	input  wire logic                         core3_fourth_pair,
	input  wire logic [`CVT_OFS_FIELD_W-1:0]  core2_first_offset_in,
	input  wire logic [`CVT_GAIN_FIELD_W-1:0] core3_fourth_gain_in,
	output logic                              trim_ready,
	output logic      [`CVT_OFS_FIELD_W-1:0]  core2_offset,
	output logic      [`CVT_OFS_FIELD_W-1:0]  core3_offset,
	output logic      [`CVT_OFS_FIELD_W-1:0]  core4_offset,
	output logic      [`CVT_OFS_FIELD_W-1:0]  core5_offset,
	output logic      [`CVT_GAIN_FIELD_W-1:0] core0_gain,
	output logic      [`CVT_GAIN_FIELD_W-1:0] core1_gain,
	output logic      [`CVT_GAIN_FIELD_W-1:0] core2_gain,
	output logic      [`CVT_GAIN_FIELD_W-1:0] core3_gain
);
	localparam int unsigned N_OFS  = 5;
	localparam int unsigned N_GAIN = 5;
	localparam int unsigned OW     = `CVT_OFS_FIELD_W;
	localparam int unsigned GW     = `CVT_GAIN_FIELD_W;
	localparam int unsigned OL     = `CVT_OFS_FIELD_LSB;
	localparam int unsigned GL     = `CVT_GAIN_FIELD_LSB;

	localparam cvt_pkg::cvt_addr_t OFS_ADDR [N_OFS] = '{
		`CVT_CORE2_SECOND_INPUT_OFFSET_TRIM,
		`CVT_CORE3_THIRD_INPUT_OFFSET_TRIM,
		`CVT_CORE3_FOURTH_INPUT_OFFSET_TRIM,
		`CVT_CORE4_OFFSET_TRIM,
		`CVT_CORE5_OFFSET_TRIM
	};
	localparam cvt_pkg::cvt_addr_t GAIN_ADDR [N_GAIN] = '{
		`CVT_CORE0_FINE_GAIN_TRIM,
		`CVT_CORE1_FINE_GAIN_TRIM,
		`CVT_CORE2_FIRST_INPUT_GAIN_TRIM,
		`CVT_CORE2_SECOND_INPUT_GAIN_TRIM,
		`CVT_CORE3_THIRD_INPUT_GAIN_TRIM
	};

	cvt_pkg::cvt_state_e state;
	logic [OW-1:0]              fuse_ofs  [N_OFS];
	logic [GW-1:0]              fuse_gain [N_GAIN];
	logic [`CVT_OFS_REG_W-1:0]  ofs_q     [N_OFS];
	logic [`CVT_GAIN_REG_W-1:0] gain_q    [N_GAIN];
	logic [N_OFS-1:0]           ofs_wr;
	logic [N_GAIN-1:0]          gain_wr;
	logic                       load;
	logic                       wr_ok;
	logic [`CVT_DATA_W-1:0]     next_rdata;

	assign fuse_ofs[0]  = fuse_core2_second_offset;
	assign fuse_ofs[1]  = fuse_core3_third_offset;
	assign fuse_ofs[2]  = fuse_core3_fourth_offset;
	assign fuse_ofs[3]  = fuse_core4_offset;
	assign fuse_ofs[4]  = fuse_core5_offset;
	assign fuse_gain[0] = fuse_core0_gain;
	assign fuse_gain[1] = fuse_core1_gain;
	assign fuse_gain[2] = fuse_core2_first_gain;
	assign fuse_gain[3] = fuse_core2_second_gain;
	assign fuse_gain[4] = fuse_core3_third_gain;

	// Reset clears the trims; fuse contents are taken once the reader reports them valid
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= cvt_pkg::CVT_WAIT_FUSE;
		end else begin
			unique case (state)
				cvt_pkg::CVT_WAIT_FUSE: begin
					if (fuse_valid) begin
						state <= cvt_pkg::CVT_LOAD;
					end
				end
				cvt_pkg::CVT_LOAD: begin
					state <= cvt_pkg::CVT_RUN;
				end
				cvt_pkg::CVT_RUN: begin
					state <= cvt_pkg::CVT_RUN;
				end
				default: begin
					state <= cvt_pkg::CVT_WAIT_FUSE;
				end
			endcase
		end
	end

	assign load  = (state == cvt_pkg::CVT_LOAD);
	// Writes before the fuse load are dropped so the load cannot undo them unseen
	assign wr_ok = reg_wr && (state == cvt_pkg::CVT_RUN);

	// Reserved bits are stored as written; software keeps them zero
	genvar gi;
	generate
		for (gi = 0; gi < N_OFS; gi++) begin : g_ofs
			assign ofs_wr[gi] = wr_ok && (reg_addr == OFS_ADDR[gi]);
			cvt_trim_reg #(
				.REG_W   (`CVT_OFS_REG_W),
				.FIELD_W (OW)
			) u_ofs (
				.ref_clk  (ref_clk),
				.arst_n   (arst_n),
				.load     (load),
				.wr_en    (ofs_wr[gi]),
				.fuse_val (fuse_ofs[gi]),
				.wr_data  (reg_wdata),
				.value    (ofs_q[gi])
			);
			chk_fuse_ofs_load: assert property (@(posedge ref_clk) disable iff (!arst_n)
				(state == cvt_pkg::CVT_LOAD) |=>
				ofs_q[gi] == `CVT_OFS_REG_W'($past(fuse_ofs[gi])))
				else $error("offset trim not loaded from fuse");
		end
		for (gi = 0; gi < N_GAIN; gi++) begin : g_gain
			assign gain_wr[gi] = wr_ok && (reg_addr == GAIN_ADDR[gi]);
			cvt_trim_reg #(
				.REG_W   (`CVT_GAIN_REG_W),
				.FIELD_W (GW)
			) u_gain (
				.ref_clk  (ref_clk),
				.arst_n   (arst_n),
				.load     (load),
				.wr_en    (gain_wr[gi]),
				.fuse_val (fuse_gain[gi]),
				.wr_data  (reg_wdata[`CVT_GAIN_REG_W-1:0]),
				.value    (gain_q[gi])
			);
			chk_fuse_gain_load: assert property (@(posedge ref_clk) disable iff (!arst_n)
				(state == cvt_pkg::CVT_LOAD) |=>
				gain_q[gi] == `CVT_GAIN_REG_W'($past(fuse_gain[gi])))
				else $error("gain trim not loaded from fuse");
		end
	endgenerate

	// Unmapped and odd offset-register addresses read as zero
	always_comb begin
		next_rdata = `CVT_RD_IDLE;
		for (int i = 0; i < N_OFS; i++) begin
			if (reg_addr == OFS_ADDR[i]) begin
				next_rdata = ofs_q[i];
			end
		end
		for (int i = 0; i < N_GAIN; i++) begin
			if (reg_addr == GAIN_ADDR[i]) begin
				next_rdata = {{(`CVT_DATA_W-`CVT_GAIN_REG_W){1'b0}}, gain_q[i]};
			end
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= `CVT_RD_IDLE;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= `CVT_RD_IDLE;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			trim_ready <= 1'b0;
		end else begin
			trim_ready <= (state == cvt_pkg::CVT_RUN);
		end
	end

	// Offset trims go out unsigned, never sign-extended
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			core2_offset <= '0;
			core3_offset <= '0;
			core4_offset <= '0;
			core5_offset <= '0;
		end else if (state == cvt_pkg::CVT_RUN) begin
			// Core 2 first pair offset lives in the neighbouring bank
			core2_offset <= core2_second_pair ? ofs_q[0][OL+OW-1:OL]
				: core2_first_offset_in;
			core3_offset <= core3_fourth_pair ? ofs_q[2][OL+OW-1:OL]
				: ofs_q[1][OL+OW-1:OL];
			core4_offset <= ofs_q[3][OL+OW-1:OL];
			core5_offset <= ofs_q[4][OL+OW-1:OL];
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			core0_gain <= '0;
			core1_gain <= '0;
			core2_gain <= '0;
			core3_gain <= '0;
		end else if (state == cvt_pkg::CVT_RUN) begin
			core0_gain <= gain_q[0][GL+GW-1:GL];
			core1_gain <= gain_q[1][GL+GW-1:GL];
			core2_gain <= core2_second_pair ? gain_q[3][GL+GW-1:GL]
				: gain_q[2][GL+GW-1:GL];
			// Core 3 fourth pair gain lives in the neighbouring bank
			core3_gain <= core3_fourth_pair ? core3_fourth_gain_in
				: gain_q[4][GL+GW-1:GL];
		end
	end

	chk_core2_second_ofs: assert property (@(posedge ref_clk) disable iff (!arst_n)
		trim_ready && $past(core2_second_pair) |-> core2_offset == $past(ofs_q[0][11:0]))
		else $error("core 2 second pair offset wrong");

	chk_core3_third_ofs: assert property (@(posedge ref_clk) disable iff (!arst_n)
		trim_ready && !$past(core3_fourth_pair) |-> core3_offset == $past(ofs_q[1][11:0]))
		else $error("core 3 third pair offset wrong");

	chk_core3_fourth_ofs: assert property (@(posedge ref_clk) disable iff (!arst_n)
		trim_ready && $past(core3_fourth_pair) |-> core3_offset == $past(ofs_q[2][11:0]))
		else $error("core 3 fourth pair offset wrong");

	chk_core4_ofs_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
		reg_wr && trim_ready && reg_addr == `CVT_CORE4_OFFSET_TRIM
		##1 !reg_wr [*2] |=> core4_offset == $past(reg_wdata[11:0], 3))
		else $error("core 4 offset does not follow its register");

	chk_core5_ofs: assert property (@(posedge ref_clk) disable iff (!arst_n)
		trim_ready |-> core5_offset == $past(ofs_q[4][11:0]))
		else $error("core 5 offset wrong");

	chk_core0_gain: assert property (@(posedge ref_clk) disable iff (!arst_n)
		trim_ready |-> core0_gain == $past(gain_q[0][4:0]))
		else $error("core 0 gain wrong");

	chk_core1_gain: assert property (@(posedge ref_clk) disable iff (!arst_n)
		trim_ready |-> core1_gain == $past(gain_q[1][4:0]))
		else $error("core 1 gain wrong");

	chk_core2_first_gain: assert property (@(posedge ref_clk) disable iff (!arst_n)
		trim_ready && !$past(core2_second_pair) |-> core2_gain == $past(gain_q[2][4:0]))
		else $error("core 2 first pair gain wrong");

	chk_core2_second_gain: assert property (@(posedge ref_clk) disable iff (!arst_n)
		trim_ready && $past(core2_second_pair) |-> core2_gain == $past(gain_q[3][4:0]))
		else $error("core 2 second pair gain wrong");

	chk_core3_third_gain: assert property (@(posedge ref_clk) disable iff (!arst_n)
		trim_ready && !$past(core3_fourth_pair) |-> core3_gain == $past(gain_q[4][4:0]))
		else $error("core 3 third pair gain wrong");

	chk_pair_switch_core2: assert property (@(posedge ref_clk) disable iff (!arst_n)
		trim_ready && $rose(core2_second_pair) ##1 trim_ready
		|-> core2_offset == $past(ofs_q[0][11:0]) && core2_gain == $past(gain_q[3][4:0]))
		else $error("core 2 trims did not switch together");

	chk_ready_after_fuse: assert property (@(posedge ref_clk) disable iff (!arst_n)
		state == cvt_pkg::CVT_WAIT_FUSE && fuse_valid |-> ##3 trim_ready)
		else $error("bank not ready three cycles after fuse valid");

	chk_read_timing: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!$past(reg_rd) |-> reg_rdata == `CVT_RD_IDLE)
		else $error("read data outside the answer cycle");

	chk_early_write_drop: assert property (@(posedge ref_clk) disable iff (!arst_n)
		state == cvt_pkg::CVT_WAIT_FUSE |-> ofs_wr == '0 && gain_wr == '0 && ofs_q[3] == '0)
		else $error("write accepted before fuse load");

	// Trims fed from the neighbouring bank follow their inputs one cycle late
	chk_core2_first_ofs: assert property (@(posedge ref_clk) disable iff (!arst_n)
		trim_ready && !$past(core2_second_pair) |-> core2_offset == $past(core2_first_offset_in))
		else $error("core 2 first pair offset wrong");

	chk_core3_fourth_gain: assert property (@(posedge ref_clk) disable iff (!arst_n)
		trim_ready && $past(core3_fourth_pair) |-> core3_gain == $past(core3_fourth_gain_in))
		else $error("core 3 fourth pair gain wrong");

	chk_core4_ofs: assert property (@(posedge ref_clk) disable iff (!arst_n)
		trim_ready |-> core4_offset == $past(ofs_q[3][11:0]))
		else $error("core 4 offset wrong");

	chk_pair_switch_core3: assert property (@(posedge ref_clk) disable iff (!arst_n)
		trim_ready && $rose(core3_fourth_pair) ##1 trim_ready
		|-> core3_offset == $past(ofs_q[2][11:0]) && core3_gain == $past(core3_fourth_gain_in))
		else $error("core 3 trims did not switch together");

	// Register write and read paths
	chk_core4_write_lands: assert property (@(posedge ref_clk) disable iff (!arst_n)
		reg_wr && trim_ready && reg_addr == `CVT_CORE4_OFFSET_TRIM |=> ofs_q[3] == $past(reg_wdata))
		else $error("core 4 offset write lost");

	chk_core0_write_lands: assert property (@(posedge ref_clk) disable iff (!arst_n)
		reg_wr && trim_ready && reg_addr == `CVT_CORE0_FINE_GAIN_TRIM
		|=> gain_q[0] == $past(reg_wdata[7:0]))
		else $error("core 0 gain write lost");

	chk_core5_read_data: assert property (@(posedge ref_clk) disable iff (!arst_n)
		reg_rd && reg_addr == `CVT_CORE5_OFFSET_TRIM |=> reg_rdata == $past(ofs_q[4]))
		else $error("core 5 offset read wrong");

	chk_core1_read_data: assert property (@(posedge ref_clk) disable iff (!arst_n)
		reg_rd && reg_addr == `CVT_CORE1_FINE_GAIN_TRIM |=> reg_rdata == {8'h00, $past(gain_q[1])})
		else $error("core 1 gain read wrong");

	chk_read_unmapped: assert property (@(posedge ref_clk) disable iff (!arst_n)
		reg_rd && reg_addr == 12'h337 |=> reg_rdata == `CVT_RD_IDLE)
		else $error("odd address read not zero");

	// Ready and trims change only at reset, load, software writes and, for cores 2 and 3, pair selection or neighbouring-bank inputs
	chk_ready_holds: assert property (@(posedge ref_clk) disable iff (!arst_n)
		trim_ready |=> trim_ready)
		else $error("ready dropped without reset");

	chk_outputs_wait_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!trim_ready |-> core4_offset == '0 && core0_gain == '0)
		else $error("trim outputs moved before fuse load");

	// Fuse changes after the load must not reach the trims
	chk_trims_hold_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
		trim_ready && !reg_wr |=> ofs_q[3] == $past(ofs_q[3]))
		else $error("trim changed without a write");

endmodule : cvt_trim_bank
`default_nettype wire

/* File: rtl/cvt_trim_reg.sv */
// One trim register: cleared by reset, loaded from fuse, written by software.
// Assumes load and write are never high in the same cycle.
`include "cvt_params.svh"
`default_nettype none
module cvt_trim_reg #(
	parameter int unsigned REG_W   = 16,
	parameter int unsigned FIELD_W = 12
) (
	input  wire logic               ref_clk,
	input  wire logic               arst_n,
	input  wire logic               load,
	input  wire logic               wr_en,
	input  wire logic [FIELD_W-1:0] fuse_val,
	input  wire logic [REG_W-1:0]   wr_data,
	output logic      [REG_W-1:0]   value
);
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			value <= REG_W'(`CVT_TRIM_RESET);
		end else if (load) begin
			// Fuse field zero-extended; reserved bits come back as zero
			value <= REG_W'(fuse_val);
		end else if (wr_en) begin
			value <= wr_data;
		end
	end
endmodule : cvt_trim_reg
`default_nettype wire

/* File: verification/cvt_trim_bank_tb.sv */
// Self-checking bench for the converter trim register bank.
// Assumes reads answer in the cycle after the strobe and fuses load once fuse_valid is high.
`include "cvt_params.svh"
`default_nettype none
module cvt_trim_bank_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk    = 1'b0;
	logic        arst_n     = 1'b0;
	logic [11:0] reg_addr   = 12'h000;
	logic [15:0] reg_wdata  = 16'h0000;
	logic        reg_wr     = 1'b0;
	logic        reg_rd     = 1'b0;
	logic        fuse_valid = 1'b0;
	logic        sel2       = 1'b0;
	logic        sel3       = 1'b0;
	logic [11:0] c2_first   = 12'h000;
	logic [4:0]  c3_fourth  = 5'h00;
	logic        rd_pend    = 1'b0;
	logic [11:0] fz [10]    = '{default: 12'h000};
	logic [15:0] rm [10];
	logic [15:0] exp_q [$];
	logic [15:0] reg_rdata;
	logic        trim_ready;
	logic [11:0] core2_offset, core3_offset, core4_offset, core5_offset;
	logic [4:0]  core0_gain, core1_gain, core2_gain, core3_gain;
	int          error_cnt   = 0;
	int          check_count = 0;
	localparam logic [11:0] ADDR [10] = '{`CVT_CORE2_SECOND_INPUT_OFFSET_TRIM,
		`CVT_CORE3_THIRD_INPUT_OFFSET_TRIM, `CVT_CORE3_FOURTH_INPUT_OFFSET_TRIM,
		`CVT_CORE4_OFFSET_TRIM, `CVT_CORE5_OFFSET_TRIM, `CVT_CORE0_FINE_GAIN_TRIM,
		`CVT_CORE1_FINE_GAIN_TRIM, `CVT_CORE2_FIRST_INPUT_GAIN_TRIM,
		`CVT_CORE2_SECOND_INPUT_GAIN_TRIM, `CVT_CORE3_THIRD_INPUT_GAIN_TRIM};
	// Reserved bits kept zero: software never sets them
	localparam logic [15:0] MSK [10] = '{16'h0FFF, 16'h0FFF, 16'h0FFF, 16'h0FFF, 16'h0FFF,
		16'h001F, 16'h001F, 16'h001F, 16'h001F, 16'h001F};

	cvt_trim_bank dut (
		.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fuse_valid(fuse_valid),
		.fuse_core2_second_offset(fz[0]), .fuse_core3_third_offset(fz[1]),
		.fuse_core3_fourth_offset(fz[2]), .fuse_core4_offset(fz[3]),
		.fuse_core5_offset(fz[4]), .fuse_core0_gain(fz[5][4:0]),
		.fuse_core1_gain(fz[6][4:0]), .fuse_core2_first_gain(fz[7][4:0]),
		.fuse_core2_second_gain(fz[8][4:0]), .fuse_core3_third_gain(fz[9][4:0]),
		.core2_second_pair(sel2), .core3_fourth_pair(sel3),
		.core2_first_offset_in(c2_first), .core3_fourth_gain_in(c3_fourth),
		.trim_ready(trim_ready), .core2_offset(core2_offset), .core3_offset(core3_offset),
		.core4_offset(core4_offset), .core5_offset(core5_offset), .core0_gain(core0_gain),
		.core1_gain(core1_gain), .core2_gain(core2_gain), .core3_gain(core3_gain)
	);

	always #5 ref_clk = ~ref_clk;

	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : cmp16

	task automatic cmp_trim(input logic [11:0] got, input logic [11:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : cmp_trim

	// Read data is judged one cycle after the strobe, idle zero otherwise
	always @(posedge ref_clk) rd_pend <= reg_rd;
	always @(negedge ref_clk) begin
		if (rd_pend && exp_q.size() == 0) begin
			cmp16(reg_rdata, 16'hXXXX, "read without note");
		end else if (rd_pend) begin
			cmp16(reg_rdata, exp_q.pop_front(), "read data");
		end else if (arst_n) begin
			cmp16(reg_rdata, `CVT_RD_IDLE, "idle read data");
		end
	end

	task automatic idle(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge ref_clk);
	endtask : idle

	// Index -1 marks a write the bank must drop
	task automatic wr(input int i, input logic [11:0] a, input logic [15:0] d);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
		if (i >= 0) rm[i] = d;
		@(posedge ref_clk);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [15:0] e);
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge ref_clk);
	endtask : rd

	task automatic rd_all();
		for (int i = 0; i < 10; i++) rd(ADDR[i], rm[i]);
		idle(2);
	endtask : rd_all

	task automatic new_fuse();
		for (int i = 0; i < 10; i++) fz[i] <= 12'($urandom) & MSK[i][11:0];
		c2_first <= 12'($urandom);
		c3_fourth <= 5'($urandom);
	endtask : new_fuse

	task automatic chk_reset();
		#1;
		cmp_trim(core2_offset | core3_offset | core4_offset | core5_offset, 12'h000, "reset ofs");
		cmp_trim({7'h00, core0_gain | core1_gain | core2_gain | core3_gain}, 12'h000, "reset gain");
		cmp_trim({11'h000, trim_ready}, 12'h000, "reset ready");
		@(posedge ref_clk);
	endtask : chk_reset

	task automatic boot();
		int n;
		n = 0;
		fuse_valid <= 1'b1;
		while (trim_ready !== 1'b1 && n < 10) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		cmp_trim({11'h000, trim_ready}, 12'h001, "fuse load done");
		for (int i = 0; i < 10; i++) rm[i] = {4'h0, fz[i]} & MSK[i];
		@(posedge ref_clk);
	endtask : boot

	task automatic chk_trim();
		#1;
		cmp_trim(core2_offset, sel2 ? rm[0][11:0] : c2_first, "core2 ofs");
		cmp_trim(core3_offset, sel3 ? rm[2][11:0] : rm[1][11:0], "core3 ofs");
		cmp_trim(core4_offset, rm[3][11:0], "core4 ofs");
		cmp_trim(core5_offset, rm[4][11:0], "core5 ofs");
		cmp_trim({7'h00, core0_gain}, rm[5][11:0], "core0 gain");
		cmp_trim({7'h00, core1_gain}, rm[6][11:0], "core1 gain");
		cmp_trim({7'h00, core2_gain}, sel2 ? rm[8][11:0] : rm[7][11:0], "core2 gain");
		cmp_trim({7'h00, core3_gain}, sel3 ? {7'h00, c3_fourth} : rm[9][11:0], "c3 gain");
		@(posedge ref_clk);
	endtask : chk_trim

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up

	// Whole run is under two hundred cycles; ten thousand means a hang
	initial begin
		#100000;
		error_cnt++;
		$display("BAD %0t watchdog expired", $time);
		wrap_up();
	end

	initial begin
		void'($urandom(39));
		new_fuse();
		repeat (5) @(posedge ref_clk);
		chk_reset();
		arst_n <= 1'b1;
		idle(2);
		wr(-1, `CVT_CORE4_OFFSET_TRIM, 16'h0ABC);
		rd(`CVT_CORE4_OFFSET_TRIM, 16'h0000);
		idle(2);
		boot();
		rd_all();
		chk_trim();
		$display("test fuse defaults done");
		for (int r = 0; r < 3; r++) begin
			for (int i = 0; i < 10; i++) begin
				wr(i, ADDR[i], r == 0 ? MSK[i] : 16'($urandom) & MSK[i] & {16{r[1]}});
			end
			rd_all();
			chk_trim();
		end
		// Lone write with quiet cycles after it, so the output follows it alone
		wr(3, ADDR[3], 16'($urandom) & MSK[3]);
		idle(3);
		chk_trim();
		$display("test write readback done");
		for (int k = 0; k < 8; k++) begin
			sel2 <= k[0];
			sel3 <= k[1];
			c2_first <= 12'($urandom);
			c3_fourth <= 5'($urandom);
			idle(3);
			chk_trim();
		end
		$display("test input selection done");
		wr(-1, 12'h337, 16'h0FFF);
		wr(-1, 12'h365, 16'h001F);
		rd(12'h337, 16'h0000);
		rd(12'h365, 16'h0000);
		rd(12'h000, 16'h0000);
		rd_all();
		$display("test unmapped access done");
		arst_n <= 1'b0;
		new_fuse();
		@(posedge ref_clk);
		chk_reset();
		arst_n <= 1'b1;
		boot();
		rd_all();
		chk_trim();
		$display("test mid-run reset done");
		idle(3);
		wrap_up();
	end
endmodule : cvt_trim_bank_tb
`default_nettype wire
